// [common/wbc_pkg.sv]
// constants, field layout and state type for the write-buffered cache unit
// assumes one 25 MHz clock and a synchronous processor-side bus partner
//
// Functional notes
// - write buffer holds at most four 32-bit writes with address and control
// - an isolated single I/O write never enters the write buffer
// - buffer accepts one write per clock; requester is released on acceptance
// - buffered write starts on the bus at once when bus free, nothing higher
// - with all buffer entries full, further write requests stall
// - buffered writes reach the bus in first-in-first-out order
// - a new read may pass buffered writes only if all are cache hits
// - passing read re-marks all buffered writes as misses; they drain first next time
// - any cache invalidation re-marks all buffered writes as misses
// - cache disabled limits write buffering to one posted write and disables any reordering
// - locked read skips cache, drains buffer, reads, then buffered locked write
// - I/O reads never allocate and are never served from the cache
// - I/O read waits until every buffered memory write has completed
// - single I/O write halts requester until buffer and the write complete
// - write hit updates the cached word and is written through to memory
// - cache is 8 Kbytes, four ways of 128 sets, 16-byte aligned lines
// - address splits into 4-bit offset, 7-bit index, 21-bit tag
// - four valid bits per set; a hit needs the way's valid bit
// - cacheable read miss with the cache enabled fetches the whole aligned 16-byte line
// - only read misses fill lines; write misses never allocate
// - read cacheable only if page allows and external side signals cacheable
// - one cache access per clock, physical address from a 20-bit page bus
// - pseudo-LRU with three bits per set, updated on hits and fills
// - fill picks an invalid way first, else pseudo-LRU; flush/reset clear valids
// - external invalidation address clears the valid bit of a matching way
package wbc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PAGE_W = 20;
  localparam int OFFS_W = 12;
  localparam int WORD_LSB = 2;
  localparam int INDEX_LSB = 4;
  localparam int INDEX_W = 7;
  localparam int TAG_LSB = 11;
  localparam int TAG_W = 21;
  localparam int NUM_WAYS = 4;
  localparam int WAY_W = 2;
  localparam int NUM_SETS = 128;
  localparam int LINE_WORDS = 4;
  localparam int WORD_W = 2;
  localparam int PLRU_W = 3;
  localparam int BUF_DEPTH = 4;
  localparam logic [PLRU_W-1:0] PLRU_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_IOW
  } ctl_state_t;
endpackage

// [rtl/wbc_cache_unit.sv]
// write-through set-associative cache with posted write buffer and bus engine
// assumes a bus partner on clk_i that acks each word and answers cacheability
//
// Implementation choices: the address-and-strobe port.
module wbc_cache_unit #(
  parameter int BUF_DEPTH = wbc_pkg::BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cache_en_i,
  input wire logic flush_i,
  input wire logic inval_valid_i,
  input wire logic [wbc_pkg::ADDR_W-1:wbc_pkg::INDEX_LSB] inval_addr_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_io_i,
  input wire logic req_io_rep_i,
  input wire logic req_lock_i,
  input wire logic req_nocache_i,
  input wire logic [wbc_pkg::PAGE_W-1:0] req_page_i,
  input wire logic [wbc_pkg::OFFS_W-1:0] req_offs_i,
  input wire logic [wbc_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [wbc_pkg::DATA_W-1:0] rd_data_o,
  output logic bus_req_o,
  output logic bus_write_o,
  output logic bus_line_o,
  output logic bus_io_o,
  output logic bus_lock_o,
  output logic [wbc_pkg::ADDR_W-1:wbc_pkg::WORD_LSB] bus_addr_o,
  output logic [wbc_pkg::DATA_W-1:0] bus_wdata_o,
  input wire logic bus_ack_i,
  input wire logic bus_ken_i,
  input wire logic [wbc_pkg::DATA_W-1:0] bus_rdata_i
);
  import wbc_pkg::*;

  localparam int PTR_W = (BUF_DEPTH > 2) ? $clog2(BUF_DEPTH) : 1;

  if (BUF_DEPTH != 2 && BUF_DEPTH != 4) begin : g_depth_check
    $error("BUF_DEPTH must be 2 or 4");
  end

  function automatic logic [WAY_W-1:0] plru_victim(input logic [PLRU_W-1:0] b);
    return b[0] ? {1'b1, b[2]} : {1'b0, b[1]};
  endfunction

  // bits point away from the most recently touched half and way
  function automatic logic [PLRU_W-1:0] plru_touch(input logic [PLRU_W-1:0] b,
                                                   input logic [WAY_W-1:0] w);
    logic [PLRU_W-1:0] r;
    r = b;
    r[0] = ~w[1];
    if (w[1]) begin
      r[2] = ~w[0];
    end else begin
      r[1] = ~w[0];
    end
    return r;
  endfunction

  function automatic logic [INDEX_W-1:0] idx_of(input logic [ADDR_W-1:INDEX_LSB] a);
    return a[TAG_LSB-1:INDEX_LSB];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:INDEX_LSB] a);
    return a[ADDR_W-1:TAG_LSB];
  endfunction

  // cache storage
  logic [TAG_W-1:0] tag_mem [NUM_WAYS][NUM_SETS];
  logic [DATA_W-1:0] data_mem [NUM_WAYS][NUM_SETS][LINE_WORDS];
  logic [NUM_WAYS-1:0] valid [NUM_SETS];
  logic [PLRU_W-1:0] plru [NUM_SETS];

  // write buffer
  logic [ADDR_W-1:WORD_LSB] wb_addr [BUF_DEPTH];
  logic [DATA_W-1:0] wb_data [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] wb_io;
  logic [BUF_DEPTH-1:0] wb_lock;
  logic [BUF_DEPTH-1:0] wb_used;
  logic [BUF_DEPTH-1:0] wb_hit;
  logic [BUF_DEPTH-1:0] next_wb_hit;
  logic [PTR_W-1:0] head;
  logic [PTR_W-1:0] tail;

  ctl_state_t state;
  logic op_buf;
  logic [WORD_W-1:0] fill_cnt;
  logic fill_keep;
  logic [INDEX_W-1:0] fill_idx;
  logic [TAG_W-1:0] fill_tag;
  logic [WAY_W-1:0] fill_way;

  logic [ADDR_W-1:0] req_addr;
  logic [INDEX_W-1:0] req_idx;
  logic [TAG_W-1:0] req_tag;
  logic [WORD_W-1:0] req_word;
  logic [INDEX_W-1:0] inval_idx;
  logic [TAG_W-1:0] inval_tag;
  logic hit;
  logic [WAY_W-1:0] hit_way;
  logic has_free;
  logic [WAY_W-1:0] free_way;
  logic [WAY_W-1:0] victim;
  logic rd_req;
  logic wr_req;
  logic cacheable;
  logic read_hit;
  logic single_io;
  logic buf_empty;
  logic buf_full;
  logic bus_free;
  logic all_hit;
  logic can_bypass;
  logic start_read;
  logic start_iow;
  logic start_buf;
  logic accept_wr;
  logic wr_hit;
  logic deq;
  logic inval_any;
  logic last_word;
  logic read_ack;
  logic fill_done;
  logic [ADDR_W-1:WORD_LSB] head_addr;

  assign req_addr = {req_page_i, req_offs_i};
  assign req_idx = idx_of(req_addr[ADDR_W-1:INDEX_LSB]);
  assign req_tag = tag_of(req_addr[ADDR_W-1:INDEX_LSB]);
  assign req_word = req_addr[INDEX_LSB-1:WORD_LSB];
  assign inval_idx = idx_of(inval_addr_i);
  assign inval_tag = tag_of(inval_addr_i);

  // tag compare across all ways of the indexed set
  always_comb begin
    hit = 1'b0;
    hit_way = '0;
    has_free = 1'b0;
    free_way = '0;
    for (int w = NUM_WAYS - 1; w >= 0; w--) begin
      if (valid[req_idx][w] && tag_mem[w][req_idx] == req_tag) begin
        hit = 1'b1;
        hit_way = w[WAY_W-1:0];
      end
      if (!valid[req_idx][w]) begin
        has_free = 1'b1;
        free_way = w[WAY_W-1:0];
      end
    end
  end

  assign victim = has_free ? free_way : plru_victim(plru[req_idx]);

  assign buf_empty = ~|wb_used;
  assign buf_full = &wb_used;
  assign bus_free = ~bus_req_o;
  assign all_hit = &(wb_hit | ~wb_used);
  assign head_addr = wb_addr[head];

  assign rd_req = req_valid_i & ~req_write_i & (state == ST_IDLE);
  assign wr_req = req_valid_i & req_write_i & (state == ST_IDLE);
  assign cacheable = ~req_io_i & ~req_lock_i & ~req_nocache_i;
  assign read_hit = rd_req & cacheable & hit;
  // only one reordering per set of writes: a pass re-marks them all as misses
  assign can_bypass = cacheable & cache_en_i & all_hit & ~buf_empty;
  assign start_read = rd_req & ~read_hit & bus_free & (buf_empty | can_bypass);
  assign single_io = req_io_i & ~req_io_rep_i;
  // with the cache off at most one write is posted, so nothing can be reordered
  assign accept_wr = wr_req & ~single_io & ~buf_full & (cache_en_i | buf_empty);
  assign start_iow = wr_req & single_io & buf_empty & bus_free;
  assign start_buf = bus_free & ~buf_empty & ~start_read;
  assign inval_any = flush_i | inval_valid_i | (start_read & ~buf_empty);
  assign wr_hit = hit & ~req_io_i & ~inval_any;
  assign deq = bus_req_o & bus_write_o & op_buf & bus_ack_i;
  assign read_ack = (state == ST_READ) & bus_ack_i;
  assign last_word = ~bus_line_o | (fill_cnt == WORD_W'(LINE_WORDS - 1)) |
                     ((fill_cnt == '0) & ~bus_ken_i);
  assign fill_done = read_ack & fill_keep & (fill_cnt == WORD_W'(LINE_WORDS - 1));

  // requester is freed on acceptance, except a single I/O write waits for the bus
  assign req_ready_o = read_hit | start_read | accept_wr |
                       ((state == ST_IOW) & bus_ack_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_read) begin
            state <= ST_READ;
          end else if (start_iow) begin
            state <= ST_IOW;
          end
        end
        ST_READ: begin
          if (bus_ack_i && last_word) begin
            state <= ST_IDLE;
          end
        end
        ST_IOW: begin
          if (bus_ack_i) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // bus engine: a read that may pass outranks buffered writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_req_o <= 1'b0;
      bus_write_o <= 1'b0;
      bus_line_o <= 1'b0;
      bus_io_o <= 1'b0;
      bus_addr_o <= '0;
      bus_wdata_o <= '0;
      op_buf <= 1'b0;
    end else if (start_read) begin
      bus_req_o <= 1'b1;
      bus_write_o <= 1'b0;
      bus_line_o <= cacheable & cache_en_i;
      bus_io_o <= req_io_i;
      bus_addr_o <= req_addr[ADDR_W-1:WORD_LSB];
      op_buf <= 1'b0;
    end else if (start_iow) begin
      bus_req_o <= 1'b1;
      bus_write_o <= 1'b1;
      bus_line_o <= 1'b0;
      bus_io_o <= 1'b1;
      bus_addr_o <= req_addr[ADDR_W-1:WORD_LSB];
      bus_wdata_o <= req_wdata_i;
      op_buf <= 1'b0;
    end else if (start_buf) begin
      bus_req_o <= 1'b1;
      bus_write_o <= 1'b1;
      bus_line_o <= 1'b0;
      bus_io_o <= wb_io[head];
      bus_addr_o <= head_addr;
      bus_wdata_o <= wb_data[head];
      op_buf <= 1'b1;
    end else if (bus_req_o && bus_ack_i) begin
      if (bus_write_o || last_word) begin
        bus_req_o <= 1'b0;
        bus_line_o <= 1'b0;
      end else begin
        // critical word first, wrapping inside the aligned line
        bus_addr_o <= {bus_addr_o[ADDR_W-1:INDEX_LSB],
                       bus_addr_o[INDEX_LSB-1:WORD_LSB] + WORD_W'(1)};
      end
    end
  end

  // lock spans the locked read until its buffered write leaves the bus
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_lock_o <= 1'b0;
    end else if (start_read && req_lock_i) begin
      bus_lock_o <= 1'b1;
    end else if (deq && wb_lock[head]) begin
      bus_lock_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fill_cnt <= '0;
      fill_keep <= 1'b0;
      fill_idx <= '0;
      fill_tag <= '0;
      fill_way <= '0;
    end else if (start_read) begin
      fill_cnt <= '0;
      fill_keep <= cacheable & cache_en_i;
      fill_idx <= req_idx;
      fill_tag <= req_tag;
      fill_way <= victim;
    end else if (read_ack) begin
      fill_cnt <= fill_cnt + WORD_W'(1);
      if (fill_cnt == '0) begin
        fill_keep <= fill_keep & bus_ken_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else begin
      rd_valid_o <= read_hit | (read_ack & (fill_cnt == '0));
      if (read_hit) begin
        rd_data_o <= data_mem[hit_way][req_idx][req_word];
      end else if (read_ack && fill_cnt == '0) begin
        rd_data_o <= bus_rdata_i;
      end
    end
  end

  // data and tags carry no reset; valid bits guard them
  always_ff @(posedge clk_i) begin
    if (accept_wr && hit && !req_io_i) begin
      data_mem[hit_way][req_idx][req_word] <= req_wdata_i;
    end
    if (read_ack && fill_keep && (fill_cnt != '0 || bus_ken_i)) begin
      data_mem[fill_way][fill_idx][bus_addr_o[INDEX_LSB-1:WORD_LSB]] <= bus_rdata_i;
    end
    if (fill_done) begin
      tag_mem[fill_way][fill_idx] <= fill_tag;
    end
  end

  // a line turns valid only when all four words arrived
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        valid[s] <= '0;
      end
    end else begin
      if (inval_valid_i) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          if (valid[inval_idx][w] && tag_mem[w][inval_idx] == inval_tag) begin
            valid[inval_idx][w] <= 1'b0;
          end
        end
      end
      // a completing fill wins over an invalidation of the old tag in its way
      if (fill_done) begin
        valid[fill_idx][fill_way] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        plru[s] <= PLRU_RESET;
      end
    end else if (read_hit || (accept_wr && wr_hit)) begin
      plru[req_idx] <= plru_touch(plru[req_idx], hit_way);
    end else if (fill_done) begin
      plru[fill_idx] <= plru_touch(plru[fill_idx], fill_way);
    end
  end

  always_comb begin
    next_wb_hit = inval_any ? '0 : wb_hit;
    if (accept_wr) begin
      next_wb_hit[tail] = wr_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      head <= '0;
      tail <= '0;
      wb_used <= '0;
      wb_hit <= '0;
    end else begin
      wb_hit <= next_wb_hit;
      if (accept_wr) begin
        wb_used[tail] <= 1'b1;
        tail <= tail + PTR_W'(1);
      end
      if (deq) begin
        wb_used[head] <= 1'b0;
        head <= head + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (accept_wr) begin
      wb_addr[tail] <= req_addr[ADDR_W-1:WORD_LSB];
      wb_data[tail] <= req_wdata_i;
      wb_io[tail] <= req_io_i;
      wb_lock[tail] <= req_lock_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_write_on_bus;
    bus_req_o && bus_write_o && !bus_line_o;
  endsequence

  sequence s_line_fill;
    start_read && cacheable && cache_en_i;
  endsequence

  chk_single_io_unbuf: assert property (start_iow |-> buf_empty ##1
    s_write_on_bus ##0 bus_io_o)
    else $error("single io write not issued directly");
  chk_write_accept: assert property (wr_req && !req_io_i && !buf_full && cache_en_i
    |-> req_ready_o ##1 wb_used != '0)
    else $error("memory write not taken at once");
  chk_free_bus_issue: assert property (bus_free && !buf_empty && !rd_req |=> s_write_on_bus)
    else $error("buffered write not started on free bus");
  chk_full_stall: assert property (wr_req && buf_full |-> !req_ready_o)
    else $error("write taken while buffer full");
  chk_fifo_order: assert property (start_buf |=> s_write_on_bus ##0
    bus_addr_o == $past(head_addr))
    else $error("buffered write out of order");
  chk_bypass_hits: assert property (start_read && !buf_empty |-> all_hit && cache_en_i)
    else $error("read passed a miss write");
  chk_bypass_remark: assert property (start_read && !buf_empty |=> wb_hit == '0)
    else $error("writes not re-marked after pass");
  chk_inval_remark: assert property (inval_valid_i || flush_i |=> wb_hit == '0)
    else $error("writes not re-marked on invalidation");
  chk_lock_drained: assert property (start_read && req_lock_i |-> buf_empty ##1
    bus_lock_o && !bus_line_o)
    else $error("locked read before drain");
  chk_io_read_order: assert property (start_read && req_io_i |-> buf_empty ##1 !bus_line_o)
    else $error("io read passed writes or cached");
  chk_iow_halt: assert property (state == ST_IOW && !bus_ack_i |-> !req_ready_o)
    else $error("requester released before io write");
  chk_fill_line: assert property (s_line_fill |=> bus_line_o && !bus_write_o)
    else $error("cacheable miss without line fill");
  chk_hit_data: assert property (read_hit |=> rd_valid_o && state == ST_IDLE)
    else $error("read hit not answered next cycle");
endmodule

// [test/wbc_bus_model.sv]
// bus-side memory model: acks each word after a settable wait, keeps written words
// assumes one clock shared with the unit; outputs change just after rising edges
module wbc_bus_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic io_i,
  input wire logic [31:2] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] dly_i,
  input wire logic ken_level_i,
  output logic ack_o,
  output logic ken_o,
  output logic [31:0] rdata_o
);
  logic [3:0] cnt;
  logic [31:0] mem [logic [30:0]];
  logic go;

  function automatic logic [31:0] word_of(input logic [30:0] k);
    return {k[29:0], 1'b1, k[30]} ^ 32'h3c3c_0f0f;
  endfunction

  assign go = req_i && !ack_o && cnt >= dly_i;

  always @(posedge clk_i) begin
    if (rst_n_i && go && write_i) begin
      mem[{io_i, addr_i}] = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      ken_o <= 1'b0;
      rdata_o <= 32'h0;
    end else if (go) begin
      ack_o <= 1'b1;
      cnt <= 4'h0;
      ken_o <= ken_level_i;
      rdata_o <= mem.exists({io_i, addr_i}) ? mem[{io_i, addr_i}] : word_of({io_i, addr_i});
    end else begin
      // nothing valid outside an ack: scramble so stale data cannot pass for a read
      ack_o <= 1'b0;
      cnt <= req_i ? cnt + 4'h1 : 4'h0;
      ken_o <= ~ken_level_i;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// [test/write_buffered_cache_unit_tb.sv]
// self-checking bench for the write-buffered cache unit
// assumes wbc_bus_model answers the bus side on the same clock
module write_buffered_cache_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wbc_pkg::*;
  localparam logic [31:0] A = 32'h0001_2344, B = 32'h0001_2b44, C = 32'h0005_6780;
  localparam logic [31:0] D = 32'h0009_a000, E = 32'h000c_0010, F = 32'h000d_0020;
  localparam logic [31:0] H = 32'h000f_0040, P = 32'h0000_0060, J = 32'h0010_0050;
  localparam logic [31:0] K = 32'h0011_0060, L = 32'h0012_0070;
  logic clk_i = 1'b0, rst_n_i = 1'b0, cache_en_i = 1'b1, flush_i = 1'b0;
  logic inval_valid_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_io_i = 1'b0;
  logic req_io_rep_i = 1'b0, req_lock_i = 1'b0, req_nocache_i = 1'b0;
  logic [31:4] inval_addr_i = 28'h0;
  logic [19:0] req_page_i = 20'h0;
  logic [11:0] req_offs_i = 12'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic req_ready_o, rd_valid_o, bus_req_o, bus_write_o, bus_line_o, bus_io_o, bus_lock_o;
  logic bus_ack_i, bus_ken_i;
  logic [31:0] rd_data_o, bus_wdata_o, bus_rdata_i;
  logic [31:2] bus_addr_o;
  logic ken = 1'b1, seen = 1'b0;
  logic [3:0] dly = 4'h2;
  logic [67:0] bq [$];
  logic [31:0] rq_q [$];
  logic [31:0] sh [logic [30:0]];
  logic [31:0] rnd = 32'h6ab9;
  int miscompares = 0, checks = 0, cyc = 0, st = 0, t = 0;

  always #20 clk_i = ~clk_i;

  wbc_cache_unit dut (
    .clk_i, .rst_n_i, .cache_en_i, .flush_i, .inval_valid_i, .inval_addr_i,
    .req_valid_i, .req_write_i, .req_io_i, .req_io_rep_i, .req_lock_i, .req_nocache_i,
    .req_page_i, .req_offs_i, .req_wdata_i, .req_ready_o, .rd_valid_o, .rd_data_o,
    .bus_req_o, .bus_write_o, .bus_line_o, .bus_io_o, .bus_lock_o, .bus_addr_o,
    .bus_wdata_o, .bus_ack_i, .bus_ken_i, .bus_rdata_i
  );

  wbc_bus_model partner (
    .clk_i, .rst_n_i, .req_i(bus_req_o), .write_i(bus_write_o), .io_i(bus_io_o),
    .addr_i(bus_addr_o), .wdata_i(bus_wdata_o), .dly_i(dly), .ken_level_i(ken),
    .ack_o(bus_ack_i), .ken_o(bus_ken_i), .rdata_o(bus_rdata_i)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] mv(input logic io, input logic [31:0] a);
    if (sh.exists({io, a[31:2]})) return sh[{io, a[31:2]}];
    return {a[31:2], 1'b1, io} ^ 32'h3c3c_0f0f;
  endfunction

  task automatic chk(input string n, input logic [67:0] e, input logic [67:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // expected bus operation, in the order it must reach the bus
  task automatic ex(input logic w, io, lk, ln, input logic [31:0] a, d = 32'h0);
    bq.push_back({w, io, lk, ln, a[31:2], d});
  endtask

  // request held until taken; valid stays up so the next call can follow at once
  task automatic rq(input logic w, io, rep, lk, nc, input logic [31:0] a, d);
    req_write_i <= w;
    req_io_i <= io;
    req_io_rep_i <= rep;
    req_lock_i <= lk;
    req_nocache_i <= nc;
    req_page_i <= a[31:12];
    req_offs_i <= a[11:0];
    req_wdata_i <= d;
    req_valid_i <= 1'b1;
    if (w) sh[{io, a[31:2]}] = d;
    else rq_q.push_back(mv(io, a));
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (req_ready_o !== 1'b1 && t < 400);
    t--;
    st += t;
    chk("request taken", 68'h1, 68'(t < 399));
    if (w && io && !rep) chk("io write ack", 68'h1, 68'(bus_ack_i));
  endtask

  task automatic rd(input logic [31:0] a);
    rq(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, d);
    rq(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, a, d);
  endtask

  task automatic settle();
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    for (int n = 0; n < 400 && (bq.size() > 0 || rq_q.size() > 0 || bus_req_o !== 1'b0);
         n++) begin
      @(posedge clk_i);
    end
  endtask

  task automatic inval(input logic [31:0] a);
    inval_addr_i <= a[31:4];
    inval_valid_i <= 1'b1;
    @(posedge clk_i);
    inval_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    logic [67:0] got;
    got = {bus_write_o, bus_io_o, bus_lock_o, bus_line_o, bus_addr_o, 32'h0};
    if (bus_write_o === 1'b1) got[31:0] = bus_wdata_o;
    if (bus_req_o !== 1'b1) begin
      seen = 1'b0;
    end else if (bus_ack_i === 1'b1 && !seen) begin
      seen = 1'b1;
      if (bq.size() == 0) chk("unexpected bus op", 68'h0, got);
      else chk("bus op", bq.pop_front(), got);
    end
    if (rd_valid_o === 1'b1) begin
      if (rq_q.size() == 0) chk("unexpected read", 68'h0, 68'h1);
      else chk("read data", 68'(rq_q.pop_front()), 68'(rd_data_o));
    end
    // the ceiling check stays last so nothing runs after the closing report
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // fill, hits on every word, a second tag in the same set
    ex(0, 0, 0, 1, A);
    rd(A);
    for (int k = 0; k < 4; k++) rd({A[31:4], k[1:0], 2'b00});
    ex(0, 0, 0, 1, B);
    rd(B);
    rd(A);
    settle();
    ex(1, 0, 0, 0, A, 32'h1111_2222);
    wr(A, 32'h1111_2222);
    rd(A);
    ex(1, 0, 0, 0, C, 32'h0bad_f00d);
    ex(0, 0, 0, 1, C);
    wr(C, 32'h0bad_f00d);
    rd(C);
    settle();
    // slow bus: a full buffer must hold off the requester
    dly <= 4'h6;
    st = 0;
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      ex(1, 0, 0, 0, D + 32'(k * 4), rnd);
      wr(D + 32'(k * 4), rnd);
      if (k == 0) chk("first write wait", 68'h0, 68'(t));
    end
    chk("write stall", 68'h1, 68'(st > 0));
    settle();
    // one read passes hit writes, the next must wait for the drain
    ex(1, 0, 0, 0, A, 32'h5);
    ex(0, 0, 0, 1, E);
    ex(1, 0, 0, 0, A + 4, 32'h6);
    ex(1, 0, 0, 0, A + 8, 32'h7);
    ex(0, 0, 0, 1, F);
    wr(A, 32'h5);
    wr(A + 4, 32'h6);
    wr(A + 8, 32'h7);
    rd(E);
    rd(F);
    settle();
    ex(1, 0, 0, 0, A, 32'h8);
    ex(1, 0, 0, 0, A + 4, 32'h9);
    ex(0, 0, 0, 1, H);
    ex(0, 0, 0, 1, B);
    wr(A, 32'h8);
    wr(A + 4, 32'h9);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    inval(B);
    rd(H);
    rd(B);
    settle();
    flush_i <= 1'b1;
    @(posedge clk_i);
    flush_i <= 1'b0;
    ex(0, 0, 0, 1, E);
    @(posedge clk_i);
    rd(E);
    settle();
    // io space: reads wait for buffered writes and are never cached
    dly <= 4'h4;
    ex(1, 0, 0, 0, A, 32'ha);
    ex(1, 0, 0, 0, A + 4, 32'hb);
    ex(0, 1, 0, 0, P);
    ex(0, 1, 0, 0, P);
    wr(A, 32'ha);
    wr(A + 4, 32'hb);
    rq(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, P, 32'h0);
    rq(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, P, 32'h0);
    ex(1, 0, 0, 0, A, 32'hc);
    ex(1, 0, 0, 0, A + 4, 32'hd);
    for (int k = 0; k < 3; k++) ex(1, 1, 0, 0, P, 32'(k + 14));
    wr(A, 32'hc);
    wr(A + 4, 32'hd);
    rq(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, P, 32'he);
    rq(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, P, 32'hf);
    rq(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, P, 32'h10);
    chk("repeated io write wait", 68'h0, 68'(t));
    settle();
    // locked read bypasses a cached line after the buffer drains
    ex(0, 0, 0, 1, A);
    ex(1, 0, 0, 0, A, 32'h1);
    ex(1, 0, 0, 0, A + 4, 32'h2);
    ex(0, 0, 1, 0, A);
    ex(1, 0, 1, 0, A, 32'h2);
    rd(A);
    wr(A, 32'h1);
    wr(A + 4, 32'h2);
    rq(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A, 32'h0);
    rq(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, A, 32'h2);
    settle();
    // refused cacheability: no fill, so a repeat goes to the bus again
    ken <= 1'b0;
    ex(0, 0, 0, 1, J);
    ex(0, 0, 0, 1, J);
    rd(J);
    rd(J);
    settle();
    ken <= 1'b1;
    ex(0, 0, 0, 0, K);
    ex(0, 0, 0, 0, K);
    rq(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, K, 32'h0);
    rq(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, K, 32'h0);
    settle();
    cache_en_i <= 1'b0;
    ex(1, 0, 0, 0, A, 32'h3);
    ex(1, 0, 0, 0, A + 4, 32'h4);
    ex(0, 0, 0, 0, L);
    wr(A, 32'h3);
    wr(A + 4, 32'h4);
    rd(L);
    settle();
    chk("pending bus ops", 68'h0, 68'(bq.size()));
    chk("pending reads", 68'h0, 68'(rq_q.size()));
    end_of_test();
  end
endmodule
